/* File: core/cacr_pkg.sv */
// Constants, field layout and types for the configuration access router.
package cacr_pkg;

    // ****************************************************************
    // Processor I/O addresses of the two registers
    // ****************************************************************
    localparam logic [15:0] CFG_SELECT_ADDR = 16'h0cf8;
    localparam logic [15:0] CFG_DATA_ADDR   = 16'h0cfc;
    localparam logic [3:0]  FULL_DWORD_BE   = 4'hf;

    // ****************************************************************
    // Select register layout and reset value
    // ****************************************************************
    localparam int          ENABLE_BIT      = 31;
    localparam int          BUS_LSB         = 16;
    localparam int          DEV_LSB         = 11;
    localparam int          FUNC_LSB        = 8;
    localparam int          REG_LSB         = 2;
    localparam logic [31:0] SELECT_RESET    = 32'h0000_0000;
    localparam logic [31:0] SELECT_WR_MASK  = 32'hffff_fffc;

    // ****************************************************************
    // Internal device numbers on logical bus 0
    // ****************************************************************
    localparam logic [4:0]  DEV_HUB_BRIDGE  = 5'h00;
    localparam logic [4:0]  DEV_GFX_BRIDGE  = 5'h01;
    localparam logic [4:0]  DEV_STREAM_PORT = 5'h03;
    localparam logic [4:0]  DEV_OVERFLOW    = 5'h06;

    // ****************************************************************
    // Cycle encodings and fixed values
    // ****************************************************************
    localparam logic [1:0]  ADDR_TYPE1_CODE = 2'h1;
    localparam logic [1:0]  ADDR_TYPE0_CODE = 2'h0;
    localparam logic [7:0]  PRIMARY_BUS_NUM = 8'h00;
    localparam logic [31:0] NO_TARGET_DATA  = 32'hffff_ffff;

    typedef enum logic [1:0] {
        TGT_INTERNAL,
        TGT_HUB_LINK,
        TGT_GFX_PORT
    } cacr_target_t;

endpackage

/* File: core/cacr_router.sv */
// Configuration select/data decode and routing of configuration cycles.
`timescale 1ns/100ps
// Overview of operation
// RULE1: Capture select register at 0CF8h-0CFBh.
// RULE2: Data window at 0CFCh-0CFFh reaches selected bytes.
// RULE3: Cycles only when select enable bit set.
// RULE4: Host loads select with full doubleword write.
// RULE5: Each window access becomes one configuration cycle.
// RULE6: Eight functions, 256 byte registers each.
// RULE7: Bus field 23:16; zero means bus 0.
// RULE8: Bus 0 device 0 is hub bridge.
// RULE9: Bus 0 device 1 is graphics bridge.
// RULE10: Bus 0 devices 3 and 6 internal too.
// RULE11: Bus outside secondary..subordinate goes hub Type 1.
// RULE12: Hub Type 1 address bits 1:0 are 01.
// RULE13: Select bits 31:2 copied to address 31:2.
// RULE14: Bus equal secondary gives graphics Type 0.
// RULE15: Type 0 device n drives one-hot idsel.
// RULE16: Bus above secondary, within subordinate: graphics Type 1.
// RULE17: Graphics bridge primary bus number reads zero.
// RULE18: Software scans bus 0, then numbers bridges.
// RULE19: Byte or word select accesses pass downstream.
// RULE20: Internal devices ignore nonzero function numbers.
// RULE21: Enable clear means no configuration cycle.
module cacr_router
    import cacr_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   ce_in,
    input  wire logic                   io_req_in,
    input  wire logic                   io_write_in,
    input  wire logic [15:0]            io_addr_in,
    input  wire logic [3:0]             io_be_in,
    input  wire logic [31:0]            io_wdata_in,
    input  wire logic [7:0]             sec_bus_in,
    input  wire logic [7:0]             sub_bus_in,
    input  wire logic                   cyc_done_in,
    input  wire logic [31:0]            cyc_rdata_in,
    output logic                        io_ack_out,
    output logic [31:0]                 io_rdata_out,
    output logic                        io_pass_out,
    output logic                        cyc_valid_out,
    output logic                        cyc_write_out,
    output cacr_pkg::cacr_target_t      cyc_target_out,
    output logic                        cyc_type1_out,
    output logic [31:0]                 cyc_addr_out,
    output logic [3:0]                  cyc_be_out,
    output logic [31:0]                 cyc_wdata_out,
    output logic [7:0]                  pri_bus_num_out
);
    import cacr_pkg::*;

    // ****************************************************************
    // Idsel decode
    // ****************************************************************
    function automatic logic [15:0] idsel_of(input logic [4:0] dev);
        idsel_of = dev[4] ? 16'h0000 : (16'h0001 << dev[3:0]); // [RULE15]
    endfunction

    typedef enum {ST_IDLE, ST_CYCLE} cacr_state_t;

    cacr_state_t  state_reg;
    logic [31:0]  select_reg;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    wire        take       = ce_in && state_reg == ST_IDLE && io_req_in && !io_ack_out;
    wire        sel_hit    = io_addr_in[15:2] == CFG_SELECT_ADDR[15:2];        // [RULE1]
    wire        data_hit   = io_addr_in[15:2] == CFG_DATA_ADDR[15:2];          // [RULE2]
    wire        full_dword = io_be_in == FULL_DWORD_BE;
    wire        sel_cap    = sel_hit && full_dword;
    wire [7:0]  bus_num    = select_reg[BUS_LSB +: 8];                         // [RULE7]
    wire [4:0]  dev_num    = select_reg[DEV_LSB +: 5];
    wire [2:0]  func_num   = select_reg[FUNC_LSB +: 3];                        // [RULE6]
    wire [5:0]  reg_num    = select_reg[REG_LSB +: 6];
    wire        cfg_on     = select_reg[ENABLE_BIT];                           // [RULE3]
    wire        bus_zero   = bus_num == 8'h00;
    wire        dev_inside = dev_num == DEV_HUB_BRIDGE                          // [RULE8]
                          || dev_num == DEV_GFX_BRIDGE                          // [RULE9]
                          || dev_num == DEV_STREAM_PORT                         // [RULE10]
                          || dev_num == DEV_OVERFLOW;
    wire        to_inside  = bus_zero && dev_inside;
    wire        to_gfx0    = !bus_zero && bus_num == sec_bus_in;               // [RULE14]
    wire        to_gfx1    = !bus_zero && bus_num > sec_bus_in
                          && bus_num <= sub_bus_in;                           // [RULE16]
    wire        refuse     = !cfg_on || (to_inside && func_num != 3'h0);       // [RULE21] [RULE20]

    // Bus 0 devices that are not ours go to the hub link as Type 0; any nonzero bus
    // number outside the graphics window goes there as Type 1.
    wire cacr_target_t route_tgt = to_inside ? TGT_INTERNAL :
                                   (to_gfx0 || to_gfx1) ? TGT_GFX_PORT :
                                   TGT_HUB_LINK;                             // [RULE11]
    wire        route_t1   = !bus_zero && !to_gfx0;
    wire [31:0] t1_addr    = {select_reg[31:2], ADDR_TYPE1_CODE};              // [RULE12] [RULE13]
    wire [31:0] t0_gfx     = {idsel_of(dev_num), 5'h00, func_num, reg_num,
                              ADDR_TYPE0_CODE};                               // [RULE15]
    wire [31:0] t0_plain   = {select_reg[31:2], ADDR_TYPE0_CODE};
    wire [31:0] route_addr = route_t1 ? t1_addr : (to_gfx0 ? t0_gfx : t0_plain);

    // ****************************************************************
    // Select register and sequencing
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg       <= ST_IDLE;
            select_reg      <= SELECT_RESET;
            io_ack_out      <= 1'b0;
            io_rdata_out    <= 32'h0000_0000;
            io_pass_out     <= 1'b0;
            cyc_valid_out   <= 1'b0;
            cyc_write_out   <= 1'b0;
            cyc_target_out  <= TGT_INTERNAL;
            cyc_type1_out   <= 1'b0;
            cyc_addr_out    <= 32'h0000_0000;
            cyc_be_out      <= 4'h0;
            cyc_wdata_out   <= 32'h0000_0000;
            pri_bus_num_out <= PRIMARY_BUS_NUM;
        end else if (ce_in) begin
            pri_bus_num_out <= PRIMARY_BUS_NUM;                                // [RULE17]
            io_ack_out      <= 1'b0;
            io_pass_out     <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (take && sel_cap) begin
                        io_ack_out   <= 1'b1;
                        io_rdata_out <= select_reg;
                        if (io_write_in) begin
                            select_reg <= io_wdata_in & SELECT_WR_MASK;        // [RULE1]
                        end
                    end else if (take && data_hit && !refuse) begin
                        state_reg      <= ST_CYCLE;                            // [RULE5]
                        cyc_valid_out  <= 1'b1;
                        cyc_write_out  <= io_write_in;
                        cyc_target_out <= route_tgt;
                        cyc_type1_out  <= route_t1;
                        cyc_addr_out   <= route_addr;
                        cyc_be_out     <= io_be_in;
                        cyc_wdata_out  <= io_wdata_in;
                    end else if (take && data_hit) begin
                        io_ack_out   <= 1'b1;                                  // [RULE21]
                        io_rdata_out <= NO_TARGET_DATA;
                    end else if (take) begin
                        // Partial select accesses and foreign ports go downstream.
                        io_pass_out <= 1'b1;                                   // [RULE19]
                        io_ack_out  <= 1'b1;
                        io_rdata_out <= 32'h0000_0000;
                    end
                end
                ST_CYCLE: begin
                    if (cyc_done_in) begin
                        state_reg     <= ST_IDLE;
                        cyc_valid_out <= 1'b0;
                        io_ack_out    <= 1'b1;
                        io_rdata_out  <= cyc_write_out ? 32'h0000_0000 : cyc_rdata_in;
                    end
                end
                default: begin
                    state_reg     <= ST_IDLE;
                    cyc_valid_out <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sel_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE1]
        take && sel_cap && io_write_in |=> io_ack_out && !cyc_valid_out
            && select_reg == ($past(io_wdata_in) & SELECT_WR_MASK))
        else $error("select register write not captured");

    window_cycle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
        take && data_hit && !refuse |=> cyc_valid_out && !io_ack_out
            && cyc_write_out == $past(io_write_in) && cyc_be_out == $past(io_be_in))
        else $error("window access did not start a cycle");

    cfg_disabled_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE21]
        take && data_hit && !cfg_on |=> !cyc_valid_out && io_ack_out
            && io_rdata_out == NO_TARGET_DATA)
        else $error("cycle produced while disabled");

    func_ignore_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE20]
        take && data_hit && cfg_on && to_inside && func_num != 3'h0
            |=> !cyc_valid_out && io_ack_out)
        else $error("internal device answered nonzero function");

    partial_pass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE19]
        take && sel_hit && !full_dword |=> io_pass_out && io_ack_out
            && select_reg == $past(select_reg))
        else $error("partial select access was captured");

    hub_type1_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE12]
        cyc_valid_out && cyc_target_out == TGT_HUB_LINK && cyc_type1_out
            |-> cyc_addr_out[1:0] == ADDR_TYPE1_CODE
            && cyc_addr_out[31:2] == select_reg[31:2]
            && (bus_num < sec_bus_in || bus_num > sub_bus_in))
        else $error("hub link Type 1 address wrong");

    gfx_idsel_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE15]
        cyc_valid_out && cyc_target_out == TGT_GFX_PORT && !cyc_type1_out
            |-> bus_num == sec_bus_in && $onehot0(cyc_addr_out[31:16])
            && (cyc_addr_out[31:16] == 16'h0000) == dev_num[4])
        else $error("graphics Type 0 idsel wrong");

    gfx_type1_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE16]
        take && data_hit && cfg_on && to_gfx1 |=> cyc_valid_out
            && cyc_target_out == TGT_GFX_PORT && cyc_type1_out)
        else $error("graphics Type 1 not routed");

    inside_route_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE9] [RULE10]
        take && data_hit && cfg_on && bus_zero && func_num == 3'h0
            && (dev_num == DEV_GFX_BRIDGE || dev_num == DEV_OVERFLOW)
            |=> cyc_target_out == TGT_INTERNAL && !cyc_type1_out)
        else $error("internal device not selected");

    primary_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE17]
        ##1 pri_bus_num_out == PRIMARY_BUS_NUM)
        else $error("primary bus number not zero");

    // ****************************************************************
    // Handshake and cycle framing checks
    // ****************************************************************
    // A frozen clock enable may stretch any output, so the pulse checks
    // below only expect a change on edges where the enable was high.

    pass_with_ack_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE19]
        io_pass_out |-> io_ack_out)
        else $error("pass strobe without acknowledge");

    ack_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
        io_ack_out && ce_in |=> !io_ack_out)
        else $error("acknowledge longer than one cycle");

    state_match_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
        cyc_valid_out == (state_reg == ST_CYCLE))
        else $error("cycle strobe and state disagree");

    busy_no_take_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
        cyc_valid_out |-> !take)
        else $error("request taken during a cycle");

    cycle_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
        cyc_valid_out && !cyc_done_in |=> cyc_valid_out && $stable(cyc_addr_out)
            && $stable(cyc_wdata_out) && $stable(cyc_be_out))
        else $error("cycle fields changed before completion");

    cycle_end_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
        cyc_valid_out && cyc_done_in && ce_in |=> !cyc_valid_out && io_ack_out)
        else $error("completed cycle not acknowledged");

    read_return_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE2]
        cyc_valid_out && cyc_done_in && ce_in && !cyc_write_out
            |=> io_rdata_out == $past(cyc_rdata_in))
        else $error("read data not returned to host");

    wdata_copy_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
        take && data_hit && !refuse |=> cyc_wdata_out == $past(io_wdata_in))
        else $error("write data not carried into cycle");

    // ****************************************************************
    // Select register and routing checks
    // ****************************************************************
    // The select register may only move on a captured doubleword write;
    // anything else must leave the routing of the next cycle untouched.

    select_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE1]
        !(take && sel_cap && io_write_in) |=> $stable(select_reg))
        else $error("select register changed without capture");

    select_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE13]
        select_reg[1:0] == 2'h0)
        else $error("select register low bits not zero");

    hub_type0_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE7]
        cyc_valid_out && cyc_target_out == TGT_HUB_LINK && !cyc_type1_out
            |-> bus_zero && !dev_inside && cyc_addr_out[1:0] == ADDR_TYPE0_CODE)
        else $error("hub link Type 0 routed wrongly");

    internal_func_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE20]
        cyc_valid_out && cyc_target_out == TGT_INTERNAL
            |-> bus_zero && func_num == 3'h0 && !cyc_type1_out)
        else $error("internal cycle with nonzero function");

    gfx_t1_addr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE16]
        cyc_valid_out && cyc_target_out == TGT_GFX_PORT && cyc_type1_out
            |-> cyc_addr_out == {select_reg[31:2], ADDR_TYPE1_CODE}
            && bus_num > sec_bus_in && bus_num <= sub_bus_in)
        else $error("graphics Type 1 address wrong");

    gfx_fields_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE15]
        cyc_valid_out && cyc_target_out == TGT_GFX_PORT && !cyc_type1_out
            |-> cyc_addr_out[10:2] == select_reg[10:2]
            && cyc_addr_out[15:11] == 5'h00)
        else $error("graphics Type 0 low fields wrong");

endmodule // cacr_router

/* File: verif/cacr_far_model.sv */
// Downstream responder that completes configuration cycles after a random wait.
`timescale 1ns/100ps
module cacr_far_model (
    input  wire logic        clk_in,
    input  wire logic        cyc_valid_out,
    input  wire logic [31:0] cyc_addr_out,
    output logic             cyc_done_in,
    output logic [31:0]      cyc_rdata_in
);
    logic [1:0] wait_cnt = 2'h0;
    initial cyc_done_in = 1'b0;
    initial cyc_rdata_in = 32'h0000_0000;
    // Read data toggles outside the done cycle so that stale data can never pass.
    always @(negedge clk_in) begin
        if (cyc_valid_out && !cyc_done_in && wait_cnt == 2'h0) begin
            cyc_done_in  <= 1'b1;
            cyc_rdata_in <= cyc_addr_out ^ 32'h5a5a_5a5a;
        end else begin
            cyc_done_in  <= 1'b0;
            cyc_rdata_in <= ~cyc_rdata_in;
            wait_cnt     <= cyc_valid_out ? wait_cnt - 2'h1 : 2'($urandom_range(3, 0));
        end
    end
endmodule // cacr_far_model

/* File: verif/cacr_tb.sv */
// Self-checking testbench for the configuration access router.
`timescale 1ns/100ps
module tb;
    import cacr_pkg::*;
    logic clk_in = 0, rst_n_in = 0, ce_in = 1, io_req_in = 0, io_write_in = 0;
    logic [15:0] io_addr_in = 16'h0000;
    logic [3:0] io_be_in = 4'h0;
    logic [31:0] io_wdata_in = 32'h0, cyc_rdata_in, io_rdata_out, cyc_addr_out, cyc_wdata_out;
    logic [7:0] sec_bus_in = 8'h00, sub_bus_in = 8'h00, pri_bus_num_out, bus;
    logic cyc_done_in, io_ack_out, io_pass_out, cyc_valid_out, cyc_write_out, cyc_type1_out;
    logic [3:0] cyc_be_out, s_be;
    cacr_target_t cyc_target_out, s_tgt;
    logic saw_cyc, s_t1, s_wr, ack_seen, pass;
    logic [31:0] s_addr, s_wd, rd;
    int miscompares = 0, n_checks = 0, cycles = 0;
    cacr_router u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .io_req_in(io_req_in), .io_write_in(io_write_in), .io_addr_in(io_addr_in),
        .io_be_in(io_be_in), .io_wdata_in(io_wdata_in), .sec_bus_in(sec_bus_in),
        .sub_bus_in(sub_bus_in), .cyc_done_in(cyc_done_in), .cyc_rdata_in(cyc_rdata_in),
        .io_ack_out(io_ack_out), .io_rdata_out(io_rdata_out), .io_pass_out(io_pass_out),
        .cyc_valid_out(cyc_valid_out), .cyc_write_out(cyc_write_out),
        .cyc_target_out(cyc_target_out), .cyc_type1_out(cyc_type1_out),
        .cyc_addr_out(cyc_addr_out), .cyc_be_out(cyc_be_out), .cyc_wdata_out(cyc_wdata_out),
        .pri_bus_num_out(pri_bus_num_out));
    cacr_far_model u_far (.clk_in(clk_in), .cyc_valid_out(cyc_valid_out),
        .cyc_addr_out(cyc_addr_out), .cyc_done_in(cyc_done_in), .cyc_rdata_in(cyc_rdata_in));
    always #12.5 clk_in = ~clk_in;
    // ****************************************************************
    // Checking, bus cycles and expectations
    // ****************************************************************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic io_op(input logic wr, input logic [15:0] a, input logic [3:0] be,
                         input logic [31:0] wd);
        int n;
        n = 0;
        saw_cyc = 0;
        {io_req_in, io_write_in, io_addr_in, io_be_in, io_wdata_in} = {1'b1, wr, a, be, wd};
        do begin
            @(negedge clk_in);
            n++;
            if (cyc_valid_out && !saw_cyc) begin
                saw_cyc = 1;
                {s_tgt, s_t1, s_wr, s_addr, s_be, s_wd} = {cyc_target_out, cyc_type1_out,
                    cyc_write_out, cyc_addr_out, cyc_be_out, cyc_wdata_out};
            end
        end while (!io_ack_out && n < 40);
        {ack_seen, rd, pass} = {io_ack_out, io_rdata_out, io_pass_out};
        io_req_in = 0;
        @(negedge clk_in);
    endtask
    function automatic logic [34:0] route(input logic [31:0] s);
        logic [7:0] b;
        logic [15:0] ids;
        b = s[23:16];
        ids = s[15] ? 16'h0000 : 16'h0001 << s[14:11];
        if (b == 8'h00)
            route = {(s[15:11] inside {DEV_HUB_BRIDGE, DEV_GFX_BRIDGE, DEV_STREAM_PORT,
                     DEV_OVERFLOW}) ? TGT_INTERNAL : TGT_HUB_LINK, 1'b0, s[31:2], 2'h0};
        else if (b == sec_bus_in) route = {TGT_GFX_PORT, 1'b0, ids, 5'h00, s[10:2], 2'h0};
        else if (b > sec_bus_in && b <= sub_bus_in)
            route = {TGT_GFX_PORT, 1'b1, s[31:2], ADDR_TYPE1_CODE};
        else route = {TGT_HUB_LINK, 1'b1, s[31:2], ADDR_TYPE1_CODE};
    endfunction
    task automatic cfg_cycle(input logic [31:0] s, input logic wr, input logic [3:0] be,
                             input logic [31:0] wd);
        logic [34:0] e;
        logic refuse;
        e = route(s);
        refuse = !s[ENABLE_BIT] || (e[34:33] == TGT_INTERNAL && s[10:8] != 3'h0);
        io_op(1'b1, CFG_SELECT_ADDR, FULL_DWORD_BE, s);
        io_op(1'b0, CFG_SELECT_ADDR, FULL_DWORD_BE, 32'h0);
        check(rd, s & SELECT_WR_MASK);
        io_op(wr, CFG_DATA_ADDR + 16'($urandom_range(3, 0)), be, wd);
        check(ack_seen, 1'b1);
        check(saw_cyc, !refuse);
        if (refuse && !wr) check(rd, NO_TARGET_DATA);
        if (!refuse) begin
            check({s_tgt, s_t1}, e[34:32]);
            check(s_addr, e[31:0]);
            check(s_wr, wr);
            if (wr) check({s_be, s_wd}, {be, wd});
            else check(rd, e[31:0] ^ 32'h5a5a_5a5a);
        end
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h7890e198));
        repeat (8) @(negedge clk_in);
        rst_n_in = 1;
        @(negedge clk_in);
        check(pri_bus_num_out, PRIMARY_BUS_NUM);
        io_op(1'b0, CFG_SELECT_ADDR, FULL_DWORD_BE, 32'h0);
        check(rd, SELECT_RESET);
        io_op(1'b1, CFG_SELECT_ADDR, FULL_DWORD_BE, 32'h8012_3457);
        io_op(1'b1, CFG_SELECT_ADDR + 16'h2, 4'hc, 32'h0);
        check(pass, 1'b1);
        io_op(1'b1, CFG_SELECT_ADDR, 4'h3, 32'h0);
        check(pass, 1'b1);
        io_op(1'b0, CFG_SELECT_ADDR, FULL_DWORD_BE, 32'h0);
        check(rd, 32'h8012_3454);
        io_op(1'b0, 16'h0080, FULL_DWORD_BE, 32'h0);
        check(pass, 1'b1);
        // Bus 0 is scanned before the bridge gets its bus numbers.
        for (int f = 0; f < 2; f++)
            for (int d = 0; d < 32; d++)
                cfg_cycle({1'b1, 15'h0, 5'(d), f ? 3'($urandom_range(7, 1)) : 3'h0,
                           6'($urandom), 2'h0}, 1'b0, FULL_DWORD_BE, 32'h0);
        sec_bus_in = 8'($urandom_range(100, 2));
        sub_bus_in = sec_bus_in + 8'($urandom_range(20, 0));
        for (int d = 0; d < 32; d++)
            cfg_cycle({1'b1, 7'h0, sec_bus_in, 5'(d), 11'($urandom) & 11'h7fc}, 1'b0,
                      FULL_DWORD_BE, 32'h0);
        repeat (80) begin
            case ($urandom_range(3, 0))
                0: bus = 8'h00;
                1: bus = sec_bus_in;
                2: bus = sec_bus_in + 8'($urandom_range(20, 1));
                default: bus = 8'($urandom);
            endcase
            cfg_cycle({$urandom_range(7, 0) != 0, 7'($urandom), bus, 14'($urandom), 2'h0},
                      1'($urandom), 4'($urandom_range(15, 1)), $urandom);
        end
        complete_run();
    end
endmodule // tb
